// ==== rtl/agc_gain_ctrl.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module agc_gain_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 shutdown_n_pin,
  input  wire logic                 short_detect,
  input  wire logic signed [7:0]    envelope,
  output logic signed [7:0]         gain,
  output logic                      low_duty_mode,
  output logic                      fault
);
  import agc_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic signed [7:0] clamp_half(
    input logic signed [9:0] v,
    input logic signed [7:0] lo,
    input logic signed [7:0] hi);
    logic signed [7:0] r;
    r = v[7:0];
    if (v < 10'(lo))
      r = lo;
    else if (v > 10'(hi))
      r = hi;
    return r;
  endfunction

  function automatic logic signed [7:0] db_to_half(input logic signed [5:0] db);
    return {db[5], db, 1'b0};
  endfunction

  // ==========================================================
  // configuration state
  logic                     agc_en;
  logic                     lim_en;
  logic                     software_shutdown_bit;
  logic [7:0]               attack;
  logic [7:0]               release_t;
  logic [7:0]               hold;
  logic signed [5:0]        fixed_db;
  logic signed [7:0]        limit;
  logic signed [7:0]        gate;
  logic signed [5:0]        max_db;
  logic [1:0]               ratio;

  // bus decode
  wire        bus_setup = psel && !penable;
  wire        bus_acc   = psel && penable;
  wire        bus_wr    = bus_acc && pwrite;
  wire        addr_hit  = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire        wr_ctrl   = bus_wr && paddr == OFS_CTRL;
  wire        clr_fault = wr_ctrl && pwdata[CTRL_FAULT];
  wire        soft_rst  = !shutdown_n_pin;

  // zero wait states; unmapped addresses fail
  assign pready  = 1'b1;
  assign pslverr = bus_acc && !addr_hit;

  // ==========================================================
  // register writes, shutdown pin restores defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      agc_en                <= RST_AGC_EN;
      lim_en                <= RST_LIM_EN;
      software_shutdown_bit <= 1'b0;
      attack                <= RST_ATTACK;
      release_t             <= RST_RELEASE;
      hold                  <= RST_HOLD;
      fixed_db              <= RST_FIXED;
      limit                 <= RST_LIMIT;
      gate                  <= RST_GATE;
      max_db                <= RST_MAX;
      ratio                 <= RST_RATIO;
    end
    else if (soft_rst)
    begin
      agc_en                <= RST_AGC_EN;
      lim_en                <= RST_LIM_EN;
      software_shutdown_bit <= 1'b0;
      attack                <= RST_ATTACK;
      release_t             <= RST_RELEASE;
      hold                  <= RST_HOLD;
      fixed_db              <= RST_FIXED;
      limit                 <= RST_LIMIT;
      gate                  <= RST_GATE;
      max_db                <= RST_MAX;
      ratio                 <= RST_RATIO;
    end
    else if (bus_wr)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          agc_en                <= pwdata[CTRL_AGC_EN];
          lim_en                <= pwdata[CTRL_LIM_EN];
          software_shutdown_bit <= pwdata[CTRL_SWS];
        end
        OFS_ATTACK:  attack    <= pwdata[7:0];
        OFS_RELEASE: release_t <= pwdata[7:0];
        OFS_HOLD:    hold      <= pwdata[7:0];
        OFS_FIXED:   fixed_db  <= pwdata[5:0];
        OFS_LEVEL:
        begin
          limit <= pwdata[LVL_LIMIT_LSB +: 8];
          gate  <= pwdata[LVL_GATE_LSB +: 8];
        end
        OFS_SHAPE:
        begin
          max_db <= pwdata[SHP_MAX_LSB +: 6];
          ratio  <= pwdata[SHP_RATIO_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // short handling: fault flag and low duty mode, set wins over host clear and software shutdown bit, shutdown pin low wins over set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault <= 1'b0;
    else if (soft_rst)
      fault <= 1'b0;
    else if (short_detect)
      fault <= 1'b1;
    else if (clr_fault)
      fault <= 1'b0;
  end

  // low duty mode leaves only through a shutdown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_duty_mode <= 1'b0;
    else if (soft_rst)
      low_duty_mode <= 1'b0;
    else if (short_detect)
      low_duty_mode <= 1'b1;
    else if (software_shutdown_bit)
      low_duty_mode <= 1'b0;
  end

  // ==========================================================
  // read data, captured in the setup phase
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_STATUS:  rd_mux = {23'h0, low_duty_mode, gain};
      OFS_CTRL:    rd_mux = {26'h0, software_shutdown_bit, 1'b0, fault, 1'b0, lim_en, agc_en};
      OFS_ATTACK:  rd_mux = {24'h0, attack};
      OFS_RELEASE: rd_mux = {24'h0, release_t};
      OFS_HOLD:    rd_mux = {24'h0, hold};
      OFS_FIXED:   rd_mux = {26'h0, fixed_db};
      OFS_LEVEL:   rd_mux = {16'h0, gate, limit};
      OFS_SHAPE:   rd_mux = {22'h0, ratio, 2'h0, max_db};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (bus_setup && !pwrite)
      prdata <= rd_mux;
  end

  // ==========================================================
  // tick divider for the interval counters
  logic [9:0] div_cnt;
  wire        tick = (div_cnt == 10'(TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 10'h000;
    else if (tick)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

  // ==========================================================
  // effective gain settings
  wire               comp_on   = (ratio != 2'h0);
  wire signed [5:0]  fix_lo    = comp_on ? FIX_MIN_COMP_DB : FIX_MIN_LIN_DB;
  wire signed [7:0]  max_half  = clamp_half(10'(db_to_half(max_db)), GAIN_MIN_HALF,
                                            db_to_half(FIX_MAX_DB));
  wire signed [7:0]  fixed_eff = clamp_half(10'(db_to_half(fixed_db)), db_to_half(fix_lo),
                                            db_to_half(FIX_MAX_DB));
  wire signed [9:0]  target_raw;
  wire signed [9:0]  target    = 10'(clamp_half(target_raw, GAIN_MIN_HALF, max_half));

  agc_target u_target (
    .envelope   (envelope),
    .fixed_half (fixed_eff),
    .ratio      (ratio),
    .target     (target_raw)
  );

  // ==========================================================
  // interval counters: attack, release, hold
  logic [2:0] tmr_done;
  logic [7:0] tmr_load [3];
  wire        gain_step;
  assign tmr_load[0] = attack;
  assign tmr_load[1] = release_t;
  assign tmr_load[2] = hold;

  for (genvar i = 0; i < 3; i++)
  begin : g_tmr
    agc_interval u_tmr (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (gain_step || soft_rst),
      .load_value (tmr_load[i]),
      .tick       (tick),
      .done       (tmr_done[i])
    );
  end

  // ==========================================================
  // step decision
  wire signed [9:0] gain_w   = 10'(gain);
  wire signed [9:0] out_lvl  = 10'(envelope) + gain_w;
  wire              gated    = envelope < gate;
  wire              agc_run  = shutdown_n_pin && !software_shutdown_bit && agc_en
                               && !gated;
  wire              over_lim = lim_en && out_lvl > 10'(limit);
  wire              room_up  = !lim_en || out_lvl + 10'sd1 <= 10'(limit);
  wire              want_dn  = over_lim || gain_w > target + DEADBAND_HALF;
  wire              want_up  = room_up && gain_w < target - DEADBAND_HALF;
  wire              hold_en  = hold != 8'h00 && hold > release_t;
  logic             after_dn;
  wire              up_ready = (after_dn && hold_en) ? tmr_done[2] : tmr_done[1];
  wire              do_dec   = agc_run && want_dn && tmr_done[0]
                               && gain > GAIN_MIN_HALF;
  wire              do_inc   = agc_run && !want_dn && want_up && up_ready
                               && gain < max_half;
  agc_step_t        step;

  assign step      = do_dec ? AGC_DOWN : (do_inc ? AGC_UP : AGC_KEEP);
  assign gain_step = (step != AGC_KEEP);

  // ==========================================================
  // gain register, one half-dB step at a time under control, fixed gain loaded at once
  logic signed [7:0] next_gain;
  always_comb
  begin
    next_gain = gain;
    if (software_shutdown_bit || !agc_en)
      next_gain = fixed_eff;
    else
      case (step)
        AGC_UP:   next_gain = gain + 8'sd1;
        AGC_DOWN: next_gain = gain - 8'sd1;
        AGC_KEEP: next_gain = gain;
        default:  next_gain = gain;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain <= db_to_half(RST_FIXED);
    else if (soft_rst)
      gain <= db_to_half(RST_FIXED);
    else
      gain <= next_gain;
  end

  // hold applies only to the first increment after a decrease
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      after_dn <= 1'b0;
    else if (soft_rst || step == AGC_UP)
      after_dn <= 1'b0;
    else if (step == AGC_DOWN)
      after_dn <= 1'b1;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_step;
    agc_run |=> (gain == $past(gain) || gain == $past(gain) + 8'sd1
                 || gain == $past(gain) - 8'sd1);
  endproperty
  a_step: assert property (p_step) else $error("gain moved more than one step");

  property p_gate;
    shutdown_n_pin && agc_en && !software_shutdown_bit && gated
      ##1 shutdown_n_pin |-> $stable(gain);
  endproperty
  a_gate: assert property (p_gate) else $error("gain moved under noise gate");

  property p_attack;
    do_dec && attack > 8'h01 |=> !do_dec [*8];
  endproperty
  a_attack: assert property (p_attack) else $error("decrements too close");

  property p_inc;
    do_inc |-> tmr_done[1] && (!(after_dn && hold_en) || tmr_done[2]);
  endproperty
  a_inc: assert property (p_inc) else $error("increment before interval");

  property p_limit;
    over_lim && agc_run && tmr_done[0] && gain > GAIN_MIN_HALF
      |=> gain == $past(gain) - 8'sd1 && !tmr_done[0] || $past(attack) == 8'h00;
  endproperty
  a_limit: assert property (p_limit) else $error("limiter did not cut gain");

  property p_fault;
    short_detect && shutdown_n_pin |=> fault && low_duty_mode;
  endproperty
  a_fault: assert property (p_fault) else $error("short not flagged");

  property p_fault_keep;
    fault && shutdown_n_pin && !clr_fault |=> fault;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault lost");

  property p_lowduty;
    low_duty_mode && shutdown_n_pin && !software_shutdown_bit |=> low_duty_mode;
  endproperty
  a_lowduty: assert property (p_lowduty) else $error("low duty left early");

  property p_fixed;
    shutdown_n_pin && (!agc_en || software_shutdown_bit) |=> gain == $past(fixed_eff);
  endproperty
  a_fixed: assert property (p_fixed) else $error("gain not fixed");

  property p_bounds;
    agc_run && gain <= max_half |=> gain <= $past(max_half) && gain >= GAIN_MIN_HALF;
  endproperty
  a_bounds: assert property (p_bounds) else $error("gain out of range");

  property p_pin;
    !shutdown_n_pin |=> gain == db_to_half(RST_FIXED) && ratio == RST_RATIO && !fault;
  endproperty
  a_pin: assert property (p_pin) else $error("shutdown did not restore");

  c_dec:   cover property (do_dec ##[1:200] do_dec);
  c_inc:   cover property (do_dec ##[1:1000] do_inc);
  c_short: cover property (short_detect ##1 clr_fault);
  c_gate:  cover property (agc_en && gated);

endmodule // agc_gain_ctrl
`default_nettype wire

// ==== rtl/agc_interval.sv ====
`timescale 1ns/1ps
`default_nettype none
module agc_interval (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       tick,
  output logic            done
);
  import agc_pkg::*;

  logic [7:0] count;

  // ==========================================================
  // countdown in ticks, restarted on every automatic gain step and on shutdown pin low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 8'h00;
    else if (load)
      count <= load_value;
    else if (tick && count != 8'h00)
      count <= count - 8'h01;
  end

  assign done = (count == 8'h00);

endmodule // agc_interval
`default_nettype wire

// ==== rtl/agc_pkg.sv ====
// Overview of operation
// - a detected output short puts the output stage into low duty cycle mode
// - low duty mode stays until shutdown pin low or software shutdown bit set
// - a short event sets the fault flag at bit 3 of register 1
// - the fault flag stays set until the host writes to clear it; here shutdown pin low also clears it
// - every automatic gain change moves the gain by exactly one 0.5 dB step
// - a nearly constant envelope leaves the gain unchanged
// - over the limiter with no attack pending: decrease at once, restart timers
// - no gain change while the attack interval is still running; here increments wait only for release or hold
// - attack expired and still above limiter: one step down, restart timers
// - release expired and below desired level: one step up, restart timers
// - attack time is the least spacing between two gain decrements
// - release time is the least spacing between two gain increments
// - hold time delays the first increment after an amplitude decrease
// - envelope below noise gate threshold freezes the gain
// - fixed gain is used with control disabled and as the start gain
// - with compression on, fixed gain spans -28 dB to +30 dB
// - with compression off, fixed gain spans 0 dB to +30 dB
// - limiter level is the largest allowed output; gain drops to keep below
// - maximum gain caps the gain and sets the compression region low end
// - gain change equals input change times one minus one over the ratio
// - compression pivots at 10 dBV input; fixed gain shifts output only
// - after a decrease, hold replaces release for the next increment only; here only when hold is above release
// - shutdown pin low returns all settings to their defaults
`default_nettype none
package agc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 10;
  localparam int TICK_CYC      = (TICK_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFS_STATUS  = 12'h000;
  localparam logic [11:0] OFS_CTRL    = 12'h004;
  localparam logic [11:0] OFS_ATTACK  = 12'h008;
  localparam logic [11:0] OFS_RELEASE = 12'h00c;
  localparam logic [11:0] OFS_HOLD    = 12'h010;
  localparam logic [11:0] OFS_FIXED   = 12'h014;
  localparam logic [11:0] OFS_LEVEL   = 12'h018;
  localparam logic [11:0] OFS_SHAPE   = 12'h01c;

  // control bit positions
  localparam int CTRL_AGC_EN = 0;
  localparam int CTRL_LIM_EN = 1;
  localparam int CTRL_FAULT  = 3;
  localparam int CTRL_SWS    = 5;
  // status bit positions
  localparam int STAT_LOWDUTY = 8;
  // level register fields
  localparam int LVL_LIMIT_LSB = 0;
  localparam int LVL_GATE_LSB  = 8;
  // shape register fields
  localparam int SHP_MAX_LSB   = 0;
  localparam int SHP_RATIO_LSB = 8;

  // ==========================================================
  // gain limits, compression pivot and deadband in dB and half-dB steps
  localparam logic signed [5:0] FIX_MIN_COMP_DB = -6'sd28;
  localparam logic signed [5:0] FIX_MIN_LIN_DB  = 6'sd0;
  localparam logic signed [5:0] FIX_MAX_DB      = 6'sd30;
  localparam logic signed [7:0] GAIN_MIN_HALF   = -8'sd56;
  localparam logic signed [7:0] PIVOT_HALF      = 8'sd20;
  localparam logic signed [9:0] DEADBAND_HALF   = 10'sd1;

  // ==========================================================
  // reset values
  localparam logic              RST_AGC_EN  = 1'b1;
  localparam logic              RST_LIM_EN  = 1'b1;
  localparam logic [7:0]        RST_ATTACK  = 8'h02;
  localparam logic [7:0]        RST_RELEASE = 8'h64;
  localparam logic [7:0]        RST_HOLD    = 8'h00;
  localparam logic signed [5:0] RST_FIXED   = 6'sd6;
  localparam logic signed [7:0] RST_LIMIT   = 8'sd15;
  localparam logic signed [7:0] RST_GATE    = -8'sd60;
  localparam logic signed [5:0] RST_MAX     = 6'sd30;
  localparam logic [1:0]        RST_RATIO   = 2'h2;

  // step decision of the controller
  typedef enum logic [1:0] {AGC_KEEP, AGC_UP, AGC_DOWN} agc_step_t;

endpackage
`default_nettype wire

// ==== rtl/agc_target.sv ====
`timescale 1ns/1ps
`default_nettype none
module agc_target (
  input  wire logic signed [7:0] envelope,
  input  wire logic signed [7:0] fixed_half,
  input  wire logic [1:0]        ratio,
  output logic signed [9:0]      target
);
  import agc_pkg::*;

  logic signed [9:0] deviation;
  logic signed [9:0] kept;
  logic signed [9:0] boost;

  // ==========================================================
  // gain follows (1 - 1/2^ratio) of input distance from pivot, none for ratio 0
  assign deviation = 10'(PIVOT_HALF) - 10'(envelope);
  assign kept      = deviation >>> ratio;
  assign boost     = (ratio == 2'h0) ? 10'sd0 : deviation - kept;
  assign target    = 10'(fixed_half) + boost;

endmodule // agc_target
`default_nettype wire

// ==== tb/agc_gain_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module agc_gain_ctrl_tb;
  import agc_pkg::*;
  logic                pclk, presetn, shutdown_n_pin, short_detect, watch;
  logic                psel, penable, pwrite, pready, pslverr, low_duty_mode, fault;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rv;
  logic signed [7:0]   envelope, gain, last_gain;
  logic signed [8:0]   dg;
  logic [32:0]         exp_q[$];
  int                  num_errors, num_checks, seed, cyc, last_chg, last_dir, att, rel, hol;

  // ==========================================================
  // instances
  agc_gain_ctrl i_agc_gain_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shutdown_n_pin(shutdown_n_pin), .short_detect(short_detect),
    .envelope(envelope), .gain(gain), .low_duty_mode(low_duty_mode), .fault(fault));
  agc_host i_agc_host (.pclk(pclk), .pready(pready), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

  // ==========================================================
  // helpers
  always #5 pclk = ~pclk;

  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    num_errors++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_agc_host.xfer(1'b1, a, d);
  endtask

  // note {pslverr, prdata} expected, then issue the read
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    i_agc_host.xfer(1'b0, a, 32'h0000_0000);
  endtask

  // direct look at the fault and low duty pins
  task automatic chk_pins(input logic f, input logic l);
    num_checks++;
    if (fault !== f || low_duty_mode !== l)
      fail("fault pins");
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task end_sim;
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // read monitor: oldest note against each completed read
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      num_checks++;
      if (exp_q.size() == 0)
        fail("read without note");
      else if ({pslverr, prdata} !== exp_q.pop_front())
        fail("read data");
    end
  end

  // gain watcher: step size and spacing of automatic changes
  always @(posedge pclk)
  begin
    cyc++;
    if (watch && gain !== last_gain)
    begin
      num_checks++;
      dg = 9'(gain) - 9'(last_gain);
      if (dg === 9'sd1)
      begin
        if (last_dir == 2 && cyc - last_chg < (hol - 1) * TICK_CYC) fail("early first rise");
        if (last_dir == 1 && cyc - last_chg < (rel - 1) * TICK_CYC) fail("early rise");
        last_dir = 1;
      end
      else if (dg === -9'sd1)
      begin
        if (last_dir == 2 && cyc - last_chg < (att - 1) * TICK_CYC) fail("early drop");
        last_dir = 2;
      end
      else
        fail("gain step size");
      last_chg = cyc;
    end
    last_gain = gain;
  end

  // watchdog
  initial
  begin
    repeat (90000) @(posedge pclk);
    fail("timeout");
    end_sim;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    shutdown_n_pin = 1'b1;
    short_detect = 1'b0;
    envelope = -8'sd100;
    watch = 1'b0;
    seed = 32'h5878;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // defaults and refusals
    rd(OFS_CTRL, 33'h003);
    rd(OFS_STATUS, 33'h00c);
    rd(OFS_ATTACK, 33'h002);
    rd(OFS_RELEASE, 33'h064);
    rd(OFS_HOLD, 33'h000);
    rd(OFS_FIXED, 33'h006);
    rd(OFS_LEVEL, 33'h0c40f);
    rd(OFS_SHAPE, 33'h21e);
    rd(12'h020, 33'h1_0000_0000);
    wr(12'h00a, 32'h0000_0007);
    rd(OFS_ATTACK, 33'h002);
    // random hold readback, random envelope kept under the gate
    rv = $random(seed);
    envelope <= -8'sd64 - $signed({2'b00, rv[13:8]});
    wr(OFS_HOLD, rv);
    rd(OFS_HOLD, {25'h0, rv[7:0]});
    // short event, host clear, software shutdown
    @(posedge pclk);
    short_detect <= 1'b1;
    @(posedge pclk);
    short_detect <= 1'b0;
    rd(OFS_CTRL, 33'h00b);
    rd(OFS_STATUS, 33'h10c);
    chk_pins(1'b1, 1'b1);
    wr(OFS_CTRL, 32'h0000_000b);
    rd(OFS_CTRL, 33'h003);
    rd(OFS_STATUS, 33'h10c);
    chk_pins(1'b0, 1'b1);
    wr(OFS_CTRL, 32'h0000_0023);
    rd(OFS_STATUS, 33'h00c);
    chk_pins(1'b0, 1'b0);
    wr(OFS_CTRL, 32'h0000_0003);
    // shutdown pin returns settings and clears the fault state
    wr(OFS_FIXED, 32'h0000_000a);
    @(posedge pclk);
    short_detect <= 1'b1;
    @(posedge pclk);
    short_detect <= 1'b0;
    shutdown_n_pin <= 1'b0;
    wait_cyc(2);
    shutdown_n_pin <= 1'b1;
    rd(OFS_FIXED, 33'h006);
    rd(OFS_CTRL, 33'h003);
    rd(OFS_STATUS, 33'h00c);
    chk_pins(1'b0, 1'b0);
    // loud input: drops spaced by attack down to the limiter
    att = 2;
    rel = 3;
    hol = 6;
    wr(OFS_ATTACK, 32'h0000_0002);
    wr(OFS_RELEASE, 32'h0000_0003);
    wr(OFS_HOLD, 32'h0000_0006);
    last_dir = 0;
    watch = 1'b1;
    envelope <= 8'sd10;
    wait_cyc(16000);
    rd(OFS_STATUS, 33'h005);
    // quiet input: hold then release spaced rises up to the limiter
    envelope <= 8'sd0;
    wait_cyc(34000);
    rd(OFS_STATUS, 33'h00f);
    // loud but under a raised gate: gain frozen
    wr(OFS_LEVEL, 32'h0000_140f);
    envelope <= 8'sd10;
    wait_cyc(8000);
    rd(OFS_STATUS, 33'h00f);
    // control off: fixed gain with its clamps
    watch = 1'b0;
    wr(OFS_CTRL, 32'h0000_0002);
    wait_cyc(2);
    rd(OFS_STATUS, 33'h00c);
    wr(OFS_FIXED, 32'h0000_0022);
    wait_cyc(2);
    rd(OFS_STATUS, 33'h0c8);
    wr(OFS_SHAPE, 32'h0000_001e);
    wait_cyc(2);
    rd(OFS_STATUS, 33'h000);
    wait_cyc(4);
    end_sim;
  end
endmodule // agc_gain_ctrl_tb
`default_nettype wire

// ==== tb/agc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// apb host model: one transfer at a time, request held until pready
module agc_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic [11:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata
);
  // idle bus from time zero
  initial
  begin
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
  end

  // setup cycle, access cycle, release after pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // agc_host
`default_nettype wire
